/* File: rtl/imx_pkg.sv */
// Constants, field layout and state codes of the mux bus front end.
// Assumes a single pclk domain and an APB master for the registers.
package imx_pkg;
  localparam int          APB_AW       = 12;
  localparam int          APB_DW       = 32;
  localparam int          SYNC_W       = 7;
  localparam logic [6:0]  SYNC_RST     = 7'h7f;
  localparam int          POS_SCL      = 0;
  localparam int          POS_SDA      = 1;
  localparam int          POS_IRQ0     = 2;
  localparam int          POS_IRQ1     = 3;
  localparam int          POS_ADDR     = 4;
  localparam logic [3:0]  BYTE_BITS    = 4'h8;
  localparam logic [3:0]  SADDR_HI_DEF = 4'h7;
  localparam logic [11:0] OFS_STAT     = 12'h000;
  localparam logic [11:0] OFS_MASK     = 12'h004;
  localparam logic [11:0] OFS_CTRL     = 12'h008;
  localparam logic [11:0] OFS_CFG      = 12'h00c;
  localparam int          STAT_W       = 4;
  localparam int          EV_START     = 0;
  localparam int          EV_STOP      = 1;
  localparam int          EV_WRITE     = 2;
  localparam int          EV_NACK      = 3;
  localparam logic [3:0]  STAT_RST     = 4'h0;
  localparam logic [3:0]  MASK_RST     = 4'h0;
  localparam logic        CFG_EN_RST   = 1'b1;
  localparam int          CH_LO_POS    = 0;
  localparam int          CH_HI_POS    = 1;
  localparam int          CH_EN_POS    = 2;
  localparam int          IRQ0_POS     = 4;
  localparam int          IRQ1_POS     = 5;
  localparam logic [7:0]  CTRL_RST     = 8'h00;

  typedef enum logic [7:0] {
    S_IDLE  = 8'h01,
    S_ADDR  = 8'h02,
    S_AACK  = 8'h04,
    S_WDATA = 8'h08,
    S_WACK  = 8'h10,
    S_RDATA = 8'h20,
    S_RACK  = 8'h40,
    S_SKIP  = 8'h80
  } imx_state_t;
endpackage

/* File: rtl/imx_ctl_if.sv */
// Carrier between the bus front end and its register slave.
// Assumes both ends run on pclk.
interface imx_ctl_if;
  logic [imx_pkg::STAT_W-1:0] ev;
  logic [7:0]                 ctrl_byte;
  logic [1:0]                 conn;
  logic                       resp_en;
  modport core (output ev, output ctrl_byte, output conn, input resp_en);
  modport regs (input ev, input ctrl_byte, input conn, output resp_en);
endinterface

/* File: rtl/imx_sync.sv */
// Two-flop synchroniser, one chain per bit.
// Assumes inputs arrive from outside the pclk domain.
module imx_sync #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        meta_r[i] <= RST[i];
        q[i]      <= RST[i];
      end else begin
        meta_r[i] <= d[i];
        q[i]      <= meta_r[i];
      end
    end
  end
endmodule // imx_sync

/* File: rtl/imx_apb_regs.sv */
// APB slave: event status, mask, control readback, config, interrupt.
// Assumes events arrive as one-cycle pulses on pclk.
module imx_apb_regs
  import imx_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_DW-1:0] pwdata,
  output logic      [APB_DW-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   irq,
  imx_ctl_if.regs                ctl
);
  logic [STAT_W-1:0] stat_r, stat_nxt, mask_r, mask_nxt;
  logic              en_r, en_nxt, irq_nxt, rdy_nxt, err_nxt;
  logic [APB_DW-1:0] rd_nxt, rdata;
  logic              setup, wr, hit;

  assign ctl.resp_en = en_r;

  always_comb begin
    setup    = psel && !penable;
    wr       = psel && penable && pready && pwrite;
    stat_nxt = stat_r | ctl.ev;
    mask_nxt = mask_r;
    en_nxt   = en_r;
    rdata    = '0;
    hit      = 1'b1;
    case (paddr)
      OFS_STAT: rdata[STAT_W-1:0] = stat_r;
      OFS_MASK: rdata[STAT_W-1:0] = mask_r;
      OFS_CTRL: rdata[9:0] = {ctl.conn, ctl.ctrl_byte};
      OFS_CFG:  rdata[0] = en_r;
      default:  hit = 1'b0;
    endcase
    // Write one to clear; a new event in the same cycle wins
    if (wr && paddr == OFS_STAT) begin
      stat_nxt = (stat_r & ~pwdata[STAT_W-1:0]) | ctl.ev;
    end
    if (wr && paddr == OFS_MASK) begin
      mask_nxt = pwdata[STAT_W-1:0];
    end
    if (wr && paddr == OFS_CFG) begin
      en_nxt = pwdata[0];
    end
    rdy_nxt = setup;
    err_nxt = setup && !hit;
    rd_nxt  = setup ? rdata : prdata;
    irq_nxt = |(stat_r & mask_r);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r  <= STAT_RST;
      mask_r  <= MASK_RST;
      en_r    <= CFG_EN_RST;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
      irq     <= 1'b0;
    end else begin
      stat_r  <= stat_nxt;
      mask_r  <= mask_nxt;
      en_r    <= en_nxt;
      pready  <= rdy_nxt;
      pslverr <= err_nxt;
      prdata  <= rd_nxt;
      irq     <= irq_nxt;
    end
  end
endmodule // imx_apb_regs

/* File: rtl/imx_i2c_front.sv */
// Bus front end of a two-channel I2C mux, slave on the upstream pair.
// Assumes SCL/SDA and the interrupt pins are asynchronous to pclk.
// Behaviour
// RULE1 - A data change while the clock is high is a bus control event.
// RULE2 - Data falling while the clock is high is a START.
// RULE3 - Data rising while the clock is high is a STOP ending the transfer.
// RULE4 - The master starts a transfer only on an idle bus.
// RULE5 - Each byte is eight bits plus one acknowledge, no byte count limit.
// RULE6 - The master gives a ninth clock for the acknowledge of each byte.
// RULE7 - The transmitter releases the data line during acknowledge.
// RULE8 - The addressed device acknowledges the address and every byte.
// RULE9 - A reading master acknowledges each byte except the last.
// RULE10 - The acknowledger holds data low over the whole ninth clock high.
// RULE11 - A reading master withholds acknowledge after its last byte.
// RULE12 - After a withheld acknowledge the device leaves data high.
// RULE13 - Of several written bytes only the last stays in control.
// RULE14 - Control bits 2..0 of 100 and 101 pick channel 0 and 1, else none.
// RULE15 - A new channel choice connects only after a STOP.
// RULE16 - Read bits 4 and 5 show the channel 0 and 1 interrupt inputs.
// RULE17 - After reset the machine waits idle for a START.
module imx_i2c_front #(
  parameter logic [3:0] SADDR_HI = imx_pkg::SADDR_HI_DEF
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic [imx_pkg::APB_AW-1:0] paddr,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [imx_pkg::APB_DW-1:0] pwdata,
  output logic      [imx_pkg::APB_DW-1:0] prdata,
  output logic                           pready,
  output logic                           pslverr,
  output logic                           irq,
  input  wire logic                      scl,
  input  wire logic                      sda,
  output logic                           sda_val,
  output logic                           sda_oe,
  input  wire logic                      chan0_irq_in_n,
  input  wire logic                      chan1_irq_in_n,
  input  wire logic [2:0]                addr_pins,
  output logic      [1:0]                downstream_bus_pair
);
  import imx_pkg::*;

  imx_ctl_if ctl ();

  logic [SYNC_W-1:0] pins_s;
  logic              scl_s, sda_s, scl_p_r, sda_p_r;
  logic              irq0_s, irq1_s;
  logic [2:0]        addr_s;
  logic              scl_rise, scl_fall, start_det, stop_det;
  logic              addr_hit;
  logic [7:0]        tx_byte;

  imx_state_t        state_r, state_nxt;
  logic [3:0]        cnt_r, cnt_nxt;
  logic [7:0]        shift_r, shift_nxt, tx_r, tx_nxt;
  logic [7:0]        ctrl_r, ctrl_nxt;
  logic              oe_nxt, rd_r, rd_nxt, acked_r, acked_nxt;
  logic              pend_r, pend_nxt;
  logic [1:0]        conn_nxt;
  logic [STAT_W-1:0] ev_r, ev_nxt;

  function automatic logic [1:0] chan_decode(input logic [7:0] c);
    logic en;
    en = c[CH_EN_POS] && !c[CH_HI_POS];
    return {en && c[CH_LO_POS], en && !c[CH_LO_POS]};
  endfunction

  imx_sync #(
    .W   (SYNC_W),
    .RST (SYNC_RST)
  ) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     ({addr_pins, chan1_irq_in_n, chan0_irq_in_n, sda, scl}),
    .q     (pins_s)
  );

  imx_apb_regs u_regs (
    .pclk    (pclk),
    .presetn (presetn),
    .paddr   (paddr),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .irq     (irq),
    .ctl     (ctl.regs)
  );

  // Open-drain pin: only the enable ever changes
  assign sda_val = 1'b0;

  assign scl_s  = pins_s[POS_SCL];
  assign sda_s  = pins_s[POS_SDA];
  assign irq0_s = pins_s[POS_IRQ0];
  assign irq1_s = pins_s[POS_IRQ1];
  assign addr_s = pins_s[POS_ADDR +: 3];

  assign scl_rise  = scl_s && !scl_p_r;
  assign scl_fall  = !scl_s && scl_p_r;
  assign start_det = scl_s && scl_p_r && sda_p_r && !sda_s; // see RULE2
  assign stop_det  = scl_s && scl_p_r && !sda_p_r && sda_s; // see RULE3
  assign addr_hit  = ctl.resp_en && shift_r[7:1] == {SADDR_HI, addr_s};

  // Read byte: stored bits with live interrupt inputs in bits 5..4
  always_comb begin
    tx_byte           = ctrl_r;
    tx_byte[IRQ0_POS] = !irq0_s; // see RULE16
    tx_byte[IRQ1_POS] = !irq1_s; // see RULE16
  end

  assign ctl.ev        = ev_r;
  assign ctl.ctrl_byte = tx_byte;
  assign ctl.conn      = downstream_bus_pair;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    shift_nxt = shift_r;
    tx_nxt    = tx_r;
    ctrl_nxt  = ctrl_r;
    oe_nxt    = sda_oe;
    rd_nxt    = rd_r;
    acked_nxt = acked_r;
    pend_nxt  = pend_r;
    conn_nxt  = downstream_bus_pair;
    ev_nxt    = '0;
    if (start_det) begin // see RULE1
      state_nxt        = S_ADDR;
      cnt_nxt          = '0;
      oe_nxt           = 1'b0;
      ev_nxt[EV_START] = 1'b1;
    end else if (stop_det) begin // see RULE1
      state_nxt       = S_IDLE;
      oe_nxt          = 1'b0;
      ev_nxt[EV_STOP] = 1'b1;
      if (pend_r) begin
        conn_nxt = chan_decode(ctrl_r); // see RULE14 see RULE15
        pend_nxt = 1'b0;
      end
    end else begin
      unique case (state_r)
        S_IDLE: begin
          oe_nxt = 1'b0; // see RULE17
        end
        S_ADDR: begin
          if (scl_rise) begin
            shift_nxt = {shift_r[6:0], sda_s};
            cnt_nxt   = cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == BYTE_BITS) begin // see RULE5
            rd_nxt = shift_r[0];
            if (addr_hit) begin
              state_nxt = S_AACK;
              oe_nxt    = 1'b1; // see RULE8
            end else begin
              state_nxt = S_SKIP;
            end
          end
        end
        S_AACK: begin
          if (scl_fall) begin
            cnt_nxt = '0;
            if (rd_r) begin
              state_nxt = S_RDATA;
              tx_nxt    = tx_byte;
              oe_nxt    = !tx_byte[7];
            end else begin
              state_nxt = S_WDATA;
              oe_nxt    = 1'b0;
            end
          end
        end
        S_WDATA: begin
          if (scl_rise) begin
            shift_nxt = {shift_r[6:0], sda_s};
            cnt_nxt   = cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == BYTE_BITS) begin // see RULE5
            state_nxt        = S_WACK;
            oe_nxt           = 1'b1; // see RULE8
            ctrl_nxt         = shift_r; // see RULE13
            pend_nxt         = 1'b1; // see RULE15
            ev_nxt[EV_WRITE] = 1'b1;
          end
        end
        S_WACK: begin
          if (scl_fall) begin // see RULE10
            state_nxt = S_WDATA;
            cnt_nxt   = '0;
            oe_nxt    = 1'b0;
          end
        end
        S_RDATA: begin
          if (scl_rise) begin
            cnt_nxt = cnt_r + 4'h1;
          end else if (scl_fall) begin
            if (cnt_r == BYTE_BITS) begin // see RULE5
              state_nxt = S_RACK;
              oe_nxt    = 1'b0; // see RULE7
            end else begin
              tx_nxt = {tx_r[6:0], 1'b1};
              oe_nxt = !tx_r[6];
            end
          end
        end
        S_RACK: begin
          if (scl_rise) begin
            acked_nxt = !sda_s;
          end else if (scl_fall) begin
            cnt_nxt = '0;
            if (acked_r) begin
              state_nxt = S_RDATA;
              tx_nxt    = tx_byte;
              oe_nxt    = !tx_byte[7];
            end else begin
              state_nxt       = S_SKIP;
              oe_nxt          = 1'b0; // see RULE12
              ev_nxt[EV_NACK] = 1'b1;
            end
          end
        end
        S_SKIP: begin
          oe_nxt = 1'b0; // see RULE12
        end
        default: begin
          state_nxt = S_IDLE;
          oe_nxt    = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r             <= S_IDLE; // see RULE17
      cnt_r               <= '0;
      shift_r             <= '0;
      tx_r                <= '0;
      ctrl_r              <= CTRL_RST;
      sda_oe              <= 1'b0;
      rd_r                <= 1'b0;
      acked_r             <= 1'b0;
      pend_r              <= 1'b0;
      downstream_bus_pair <= '0;
      ev_r                <= '0;
      scl_p_r             <= 1'b1;
      sda_p_r             <= 1'b1;
    end else begin
      state_r             <= state_nxt;
      cnt_r               <= cnt_nxt;
      shift_r             <= shift_nxt;
      tx_r                <= tx_nxt;
      ctrl_r              <= ctrl_nxt;
      sda_oe              <= oe_nxt;
      rd_r                <= rd_nxt;
      acked_r             <= acked_nxt;
      pend_r              <= pend_nxt;
      downstream_bus_pair <= conn_nxt;
      ev_r                <= ev_nxt;
      scl_p_r             <= scl_s;
      sda_p_r             <= sda_s;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  high_change_ctl_a: assert property ( // see RULE1
    (scl_s && scl_p_r && sda_s != sda_p_r)
    |=> (state_r == S_ADDR || state_r == S_IDLE) && !sda_oe)
    else $error("data change with clock high not taken as control");

  start_enters_addr_a: assert property ( // see RULE2
    start_det |=> state_r == S_ADDR && cnt_r == 4'h0)
    else $error("start did not begin address phase");

  stop_ends_xfer_a: assert property ( // see RULE3
    stop_det && !start_det |=> state_r == S_IDLE && !sda_oe)
    else $error("stop did not end transfer");

  byte_len_a: assert property ( // see RULE5
    $rose(state_r == S_WACK) |-> $past(cnt_r) == BYTE_BITS)
    else $error("write ack not after eight bits");

  read_ack_free_a: assert property ( // see RULE7
    state_r == S_RACK |-> !sda_oe)
    else $error("data line driven during master acknowledge");

  addr_ack_a: assert property ( // see RULE8
    state_r == S_ADDR && scl_fall && cnt_r == BYTE_BITS && addr_hit
    && !start_det && !stop_det |=> state_r == S_AACK && sda_oe)
    else $error("matching address not acknowledged");

  ack_hold_a: assert property ( // see RULE10
    state_r == S_WACK && scl_s |-> sda_oe ##1 (sda_oe || !scl_p_r
    || stop_det || start_det || state_r != S_WACK))
    else $error("acknowledge released during clock high");

  nack_release_a: assert property ( // see RULE12
    $past(state_r) == S_RACK && state_r == S_SKIP
    |-> !sda_oe && !acked_r ##1 !sda_oe)
    else $error("line not released after withheld acknowledge");

  last_byte_kept_a: assert property ( // see RULE13
    state_r == S_WDATA && scl_fall && cnt_r == BYTE_BITS
    && !start_det && !stop_det |=> ctrl_r == $past(shift_r) && pend_r)
    else $error("received byte not stored");

  decode_a: assert property ( // see RULE14
    stop_det && pend_r
    |=> downstream_bus_pair == chan_decode($past(ctrl_r)))
    else $error("channel decode wrong");

  conn_at_stop_a: assert property ( // see RULE15
    $changed(downstream_bus_pair) |-> $past(stop_det))
    else $error("channel changed without stop");

  irq_bits_a: assert property ( // see RULE16
    state_r == S_AACK && scl_fall && rd_r && !start_det && !stop_det
    |=> tx_r[IRQ1_POS:IRQ0_POS] == ~$past({irq1_s, irq0_s}))
    else $error("read byte does not show interrupt inputs");

  idle_quiet_a: assert property ( // see RULE17
    state_r == S_IDLE && !start_det |=> state_r == S_IDLE && !sda_oe)
    else $error("idle machine reacted without start");

  write_cov: cover property (ev_r[EV_WRITE]);
  nack_cov: cover property (ev_r[EV_NACK]);
  conn_cov: cover property ($changed(downstream_bus_pair));
  restart_cov: cover property (start_det && state_r != S_IDLE);
endmodule // imx_i2c_front

/* File: test/imx_i2c_master.sv */
// Upstream bus master model: drives SCL, pulls or releases SDA.
// Assumes a pulled-up SDA wire formed by the bench from all drivers.
module imx_i2c_master #(
  parameter int H = 12
) (
  input  wire logic pclk,
  input  wire logic sda_in,
  output logic      scl,
  output logic      sda_drv
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Start or repeated start
  task automatic start();
    wt(H / 2);
    sda_drv <= 1'b1;
    wt(H / 2);
    scl <= 1'b1;
    wt(H);
    sda_drv <= 1'b0;
    wt(H);
    scl <= 1'b0;
  endtask

  task automatic stop();
    wt(H / 2);
    sda_drv <= 1'b0;
    wt(H / 2);
    scl <= 1'b1;
    wt(H);
    sda_drv <= 1'b1;
    wt(H);
  endtask

  // Clock low with no start, for stray activity
  task automatic lower();
    wt(H);
    scl <= 1'b0;
  endtask

  // One bit; data moves only while the clock is low
  task automatic bit_x(input logic b, output logic r);
    logic r1;
    wt(H / 2);
    sda_drv <= b;
    wt(H / 2);
    scl <= 1'b1;
    wt(2);
    r1 = sda_in;
    wt(H - 2);
    r = (r1 === sda_in) ? r1 : 1'bx;
    scl <= 1'b0;
  endtask

  // Eight bits then the acknowledge clock
  task automatic xfer(input logic [7:0] d, input logic ack_out,
                      output logic [7:0] rx, output logic ack_in);
    for (int i = 7; i >= 0; i--) bit_x(d[i], rx[i]);
    bit_x(ack_out, ack_in);
  endtask
endmodule // imx_i2c_master

/* File: test/tb.sv */
// Self-checking bench of the mux bus front end against a small model.
// Assumes the master model in imx_i2c_master and an APB master here.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import imx_pkg::*;

  logic        pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        pready, pslverr, irq, sda_val, sda_oe, scl, sda_drv, e, ak;
  logic        chan0_irq_in_n, chan1_irq_in_n;
  logic [2:0]  apins;
  logic [1:0]  conn, conn_m;
  logic [6:0]  saddr;
  logic [7:0]  rx, byt, last;
  logic [7:0]  wq [$];
  logic [3:0]  mask_m;
  int          err_total, n_checks, seed, nb;
  wire         sda_w = sda_drv & (sda_oe ? sda_val : 1'b1);
  logic [11:0] ofs_t [4] = '{OFS_STAT, OFS_MASK, OFS_CTRL, OFS_CFG};
  logic [31:0] rst_t [4] = '{32'h0, 32'h0, 32'h0, 32'h1};

  imx_i2c_front u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .scl(scl), .sda(sda_w), .sda_val(sda_val), .sda_oe(sda_oe),
    .chan0_irq_in_n(chan0_irq_in_n), .chan1_irq_in_n(chan1_irq_in_n),
    .addr_pins(apins), .downstream_bus_pair(conn));
  imx_i2c_master u_mst (.pclk(pclk), .sda_in(sda_w), .scl(scl),
    .sda_drv(sda_drv));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  function automatic logic [7:0] rd_exp(input logic [7:0] c);
    return {c[7:6], ~chan1_irq_in_n, ~chan0_irq_in_n, c[3:0]};
  endfunction

  function automatic logic [1:0] dec(input logic [7:0] c);
    return c[2] ? (c[1] ? 2'b00 : (c[0] ? 2'b10 : 2'b01)) : 2'b00;
  endfunction

  task automatic chk(input string nm, input logic [31:0] ex,
                     input logic [31:0] got);
    n_checks++;
    if (got !== ex) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic er);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic summarize();
    if (err_total == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (80000) @(posedge pclk);
    err_total++;
    summarize();
  end

  initial begin
    seed = 32'hfb54ce75;
    err_total = 0;
    n_checks = 0;
    {psel, penable, pwrite, presetn} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    chan0_irq_in_n = 1'b1;
    chan1_irq_in_n = 1'b1;
    apins = 3'($random(seed));
    saddr = {SADDR_HI_DEF, apins};
    conn_m = 2'b00;
    last = 8'h00;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, ofs_t[i], 32'h0, q, e);
      chk("reset value", rst_t[i], q);
      chk("mapped err", 32'h0, 32'(e));
    end
    apb(1'b1, 12'h010, 32'hffffffff, q, e);
    apb(1'b0, 12'h010, 32'h0, q, e);
    chk("unmapped data", 32'h0, q);
    chk("unmapped err", 32'h1, 32'(e));
    apb(1'b1, OFS_CTRL, 32'h000000ff, q, e);
    u_mst.lower();
    u_mst.xfer({saddr, 1'b0}, 1'b1, rx, ak);
    chk("ack before start", 32'h1, 32'(ak));
    u_mst.stop();
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, OFS_STAT, 32'hf, q, e);
      mask_m = 4'($random(seed));
      apb(1'b1, OFS_MASK, 32'(mask_m), q, e);
      chan0_irq_in_n <= 1'($random(seed));
      chan1_irq_in_n <= 1'($random(seed));
      nb = 1 + (i % 3);
      u_mst.start();
      u_mst.xfer({saddr, 1'b0}, 1'b1, rx, ak);
      chk("write addr ack", 32'h0, 32'(ak));
      for (int j = 0; j < nb; j++) begin
        byt = 8'($random(seed));
        if (j == nb - 1) byt[2:0] = 3'(i);
        wq.push_back(byt);
        last = wq[$];
        u_mst.xfer(byt, 1'b1, rx, ak);
        chk("data ack", 32'h0, 32'(ak));
      end
      u_mst.start();
      u_mst.xfer({saddr, 1'b1}, 1'b1, rx, ak);
      chk("read addr ack", 32'h0, 32'(ak));
      for (int k = 0; k <= i % 2; k++) begin
        u_mst.xfer(8'hff, (k == i % 2), rx, ak);
        chk("read byte", 32'(rd_exp(last)), 32'(rx));
      end
      u_mst.wt(6);
      chk("release after nack", 32'h0, 32'(sda_oe));
      chk("conn before stop", 32'(conn_m), 32'(conn));
      u_mst.stop();
      conn_m = dec(last);
      chk("conn after stop", 32'(conn_m), 32'(conn));
      apb(1'b0, OFS_CTRL, 32'h0, q, e);
      chk("ctrl reg", {22'h0, conn_m, rd_exp(last)}, q);
      apb(1'b0, OFS_STAT, 32'h0, q, e);
      chk("status", 32'hf, q);
      chk("irq set", 32'(|mask_m), 32'(irq));
      apb(1'b1, OFS_STAT, 32'hf, q, e);
      u_mst.wt(2);
      chk("irq clear", 32'h0, 32'(irq));
    end
    for (int c = 0; c < 2; c++) begin
      apb(1'b1, OFS_CFG, 32'(c == 0), q, e);
      apb(1'b1, OFS_STAT, 32'hf, q, e);
      u_mst.start();
      u_mst.xfer({(c == 0) ? saddr ^ 7'h01 : saddr, 1'b0}, 1'b1, rx, ak);
      chk("no ack", 32'h1, 32'(ak));
      u_mst.xfer(8'h04, 1'b1, rx, ak);
      u_mst.stop();
      chk("conn kept", 32'(conn_m), 32'(conn));
      apb(1'b0, OFS_STAT, 32'h0, q, e);
      chk("status", 32'h3, q);
    end
    summarize();
  end
endmodule // tb
